// ==== core/ldd_fault_ctrl.sv ====
// laser driver tuning outputs and laser safety supervisor
// Overview of operation
// - equalizer on bit low switches the equalizer off and bypasses it.
// - enabled equalizer strength is inverse: code 00 strongest, FF weakest.
// - crossing shift sign bit 7 high shifts positive, low shifts negative.
// - 7-bit crossing magnitude: zero means no shift, all ones largest shift.
// - limiter direction bit 3 high lowers bias current, low raises it.
// - 3-bit limiter magnitude: 000 no change, 111 largest change.
// - high drive range bit allows 100 mA modulation, clear limits 80 mA.
// - bias monitor above reference voltage is a fault condition.
// - photodiode current above 150 percent of its target is a fault.
// - bias converter dropping more than half in one step is a fault.
// - fault with detection on zeroes both currents and latches fault output.
// - fault output released while shutdown asserted or output on bit clear.
// - fault gone after disable: resume prior settings after negate time, unless a latched fault was disabled for less than the fault reset time.
// - fault still present when disable ends: fault output at once, currents off.
// - fault detect on bit at bit 3 turns detection on when set.
`timescale 1ns/10ps
module ldd_fault_ctrl
	import ldd_ctrl_pkg::*;
(
	input  wire logic       CLK_SYS,
	input  wire logic       RSTN,
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE_N,
	input  wire logic       SHUTDOWN_PIN,
	input  wire logic       BIAS_MON_ABOVE_REF,
	input  wire logic [7:0] PD_CURRENT,
	input  wire logic [9:0] BIAS_DAC,
	output logic            FAULT_OUTPUT,
	output logic            DRIVE_ON,
	output logic            EQ_ACTIVE,
	output logic [7:0]      EQ_STRENGTH,
	output logic            XSHIFT_POSITIVE,
	output logic [6:0]      XSHIFT_MAG,
	output logic            LIM_LOWER,
	output logic [2:0]      LIM_MAG,
	output logic            MOD_HIGH_RANGE
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0]        l_ctrl;
	logic [7:0]        l_eq;
	logic [7:0]        l_cross;
	logic [7:0]        l_lim;
	logic [7:0]        l_range;
	logic [7:0]        l_pdt;
	logic              l_wr_tog;
	logic [7:0]        status_r;
	logic              wt_s1_r;
	logic              wt_s2_r;
	logic              wt_s3_r;
	logic [7:0]        ctrl_r;
	logic [7:0]        pdt_r;
	logic              shut_s1_r;
	logic              shut_s2_r;
	logic              mon_s1_r;
	logic              mon_s2_r;
	logic [7:0]        pd_s1_r;
	logic [7:0]        pd_s2_r;
	logic [9:0]        dac_s1_r;
	logic [9:0]        dac_s2_r;
	logic [9:0]        dac_prev_r;
	logic              cond_mon;
	logic              cond_pd;
	logic              cond_dac;
	logic              disable_req;
	logic              fault_hit;
	sup_state_t        state_r;
	sup_state_t        state_nxt;
	logic [TIMER_W-1:0] timer_r;
	logic [TIMER_W-1:0] timer_nxt;
	logic              held_r;
	logic              held_nxt;

	localparam logic [TIMER_W-1:0] RESET_CNT  = TIMER_W'(FAULT_RESET_CYC);
	localparam logic [TIMER_W-1:0] NEGATE_CNT = TIMER_W'(OFF_NEGATE_CYC);

	// doubles a code so ratio compares stay in integers
	function automatic logic [11:0] dbl(input logic [9:0] v);
		dbl = {1'b0, v, 1'b0};
	endfunction : dbl

	// ------------------------------------------------------------
	// link side
	// ------------------------------------------------------------
	ldd_twi_link u_link (
		.scl       (SCL),
		.rst_n     (RSTN),
		.sda_in    (SDA_IN),
		.sda_out   (SDA_OUT),
		.sda_oe_n  (SDA_OE_N),
		.status_in (status_r),
		.ctrl_r    (l_ctrl),
		.eq_r      (l_eq),
		.cross_r   (l_cross),
		.lim_r     (l_lim),
		.range_r   (l_range),
		.pdt_r     (l_pdt),
		.wr_tog_r  (l_wr_tog)
	);

	// write toggle crossing; the register copies are stable once it lands
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			wt_s1_r <= 1'b0;
			wt_s2_r <= 1'b0;
			wt_s3_r <= 1'b0;
		end else begin
			wt_s1_r <= l_wr_tog;
			wt_s2_r <= wt_s1_r;
			wt_s3_r <= wt_s2_r;
		end
	end

	// ------------------------------------------------------------
	// tuning outputs, updated on each landed write
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_r          <= CTRL_RST;
			pdt_r           <= PD_TARGET_RST;
			EQ_ACTIVE       <= CTRL_RST[CTRL_EQ_ON_BIT];
			EQ_STRENGTH     <= ~EQ_SETTING_RST;
			XSHIFT_POSITIVE <= CROSS_SHIFT_RST[CROSS_SIGN_BIT];
			XSHIFT_MAG      <= CROSS_SHIFT_RST[6:0];
			LIM_LOWER       <= LIM_TRIM_RST[LIM_DIR_BIT];
			LIM_MAG         <= LIM_TRIM_RST[2:0];
			MOD_HIGH_RANGE  <= DRIVE_RANGE_RST[RANGE_HIGH_BIT];
		end else if (wt_s2_r != wt_s3_r) begin
			ctrl_r          <= l_ctrl;
			pdt_r           <= l_pdt;
			EQ_ACTIVE       <= l_ctrl[CTRL_EQ_ON_BIT];
			EQ_STRENGTH     <= ~l_eq;
			XSHIFT_POSITIVE <= l_cross[CROSS_SIGN_BIT];
			XSHIFT_MAG      <= l_cross[6:0];
			LIM_LOWER       <= l_lim[LIM_DIR_BIT];
			LIM_MAG         <= l_lim[2:0];
			MOD_HIGH_RANGE  <= l_range[RANGE_HIGH_BIT];
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// the multi-bit codes are slow analog readings; a torn sample lasts one cycle
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			shut_s1_r  <= 1'b0;
			shut_s2_r  <= 1'b0;
			mon_s1_r   <= 1'b0;
			mon_s2_r   <= 1'b0;
			pd_s1_r    <= 8'h00;
			pd_s2_r    <= 8'h00;
			dac_s1_r   <= 10'h000;
			dac_s2_r   <= 10'h000;
			dac_prev_r <= 10'h000;
		end else begin
			shut_s1_r  <= SHUTDOWN_PIN;
			shut_s2_r  <= shut_s1_r;
			mon_s1_r   <= BIAS_MON_ABOVE_REF;
			mon_s2_r   <= mon_s1_r;
			pd_s1_r    <= PD_CURRENT;
			pd_s2_r    <= pd_s1_r;
			dac_s1_r   <= BIAS_DAC;
			dac_s2_r   <= dac_s1_r;
			dac_prev_r <= dac_s2_r;
		end
	end

	// ------------------------------------------------------------
	// fault conditions
	// ------------------------------------------------------------
	assign cond_mon  = mon_s2_r;
	assign cond_pd   = dbl({2'b00, pd_s2_r}) >
		(dbl({2'b00, pdt_r}) + {4'h0, pdt_r});
	assign cond_dac  = dbl(dac_s2_r) < {2'b00, dac_prev_r};
	assign fault_hit = ctrl_r[CTRL_FAULT_DET]
		& (cond_mon | cond_pd | cond_dac);
	assign disable_req = shut_s2_r | ~ctrl_r[CTRL_OUTPUT_ON];

	// ------------------------------------------------------------
	// safety supervisor
	// ------------------------------------------------------------
	// held_r remembers a latched fault across a disable that was too short
	always_comb begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		held_nxt  = held_r;
		unique case (state_r)
			ST_RUN: begin
				if (disable_req) begin
					state_nxt = ST_DISABLED;
					timer_nxt = RESET_CNT;
					held_nxt  = 1'b0;
				end else if (fault_hit) begin
					state_nxt = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (disable_req) begin
					state_nxt = ST_DISABLED;
					timer_nxt = RESET_CNT;
					held_nxt  = 1'b1;
				end
			end
			ST_DISABLED: begin
				if (timer_r != '0) begin
					timer_nxt = timer_r - 1'b1;
				end
				if (!disable_req) begin
					if ((held_r && timer_r != '0) || fault_hit) begin
						state_nxt = ST_FAULT;
					end else begin
						state_nxt = ST_RESUME;
						timer_nxt = NEGATE_CNT;
					end
				end
			end
			ST_RESUME: begin
				if (disable_req) begin
					state_nxt = ST_DISABLED;
					timer_nxt = RESET_CNT;
					held_nxt  = 1'b0;
				end else if (fault_hit) begin
					state_nxt = ST_FAULT;
				end else if (timer_r <= 1) begin
					state_nxt = ST_RUN;
				end else begin
					timer_nxt = timer_r - 1'b1;
				end
			end
			default: begin
				state_nxt = ST_FAULT;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= ST_RUN;
			timer_r <= '0;
			held_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			held_r  <= held_nxt;
		end
	end

	// ------------------------------------------------------------
	// drive and fault pins
	// ------------------------------------------------------------
	// registered from the next state so the pins track the state flops exactly, except that reset loads DRIVE_ON low while state_r is ST_RUN
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			FAULT_OUTPUT <= 1'b0;
			DRIVE_ON     <= 1'b0;
		end else begin
			FAULT_OUTPUT <= (state_nxt == ST_FAULT);
			DRIVE_ON     <= (state_nxt == ST_RUN);
		end
	end

	// status readable over the link
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			status_r <= 8'h00;
		end else begin
			status_r <= {(state_nxt == ST_FAULT), (state_nxt == ST_RUN), state_nxt,
				cond_mon, cond_pd, cond_dac, shut_s2_r};
		end
	end

endmodule : ldd_fault_ctrl

// ==== core/ldd_ctrl_pkg.sv ====
// constants and types shared by the laser driver control logic
package ldd_ctrl_pkg;

	// ------------------------------------------------------------
	// two-wire link addressing
	// ------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR        = 7'h2A; // arbitrary value
	localparam logic [7:0] REG_CTRL        = 8'h00;
	localparam logic [7:0] REG_EQ_SETTING  = 8'h01;
	localparam logic [7:0] REG_CROSS_SHIFT = 8'h02;
	localparam logic [7:0] REG_LIM_TRIM    = 8'h03;
	localparam logic [7:0] REG_DRIVE_RANGE = 8'h04;
	localparam logic [7:0] REG_PD_TARGET   = 8'h05;
	localparam logic [7:0] REG_STATUS      = 8'h06;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_EQ_ON_BIT    = 1;
	localparam int CTRL_FAULT_DET    = 3;
	localparam int CTRL_OUTPUT_ON    = 6;
	localparam int CROSS_SIGN_BIT    = 7;
	localparam int LIM_DIR_BIT       = 3;
	localparam int RANGE_HIGH_BIT    = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RST        = 8'h40;
	localparam logic [7:0] EQ_SETTING_RST  = 8'hFF;
	localparam logic [7:0] CROSS_SHIFT_RST = 8'h00;
	localparam logic [7:0] LIM_TRIM_RST    = 8'h00;
	localparam logic [7:0] DRIVE_RANGE_RST = 8'h00;
	localparam logic [7:0] PD_TARGET_RST   = 8'h80;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_SYS_NS        = 40;
	localparam int FAULT_RESET_NS    = 1000;
	localparam int OFF_NEGATE_NS     = 2000;
	localparam int FAULT_RESET_CYC   = (FAULT_RESET_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int OFF_NEGATE_CYC    = (OFF_NEGATE_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int TIMER_W           = 8;

	// supervisor states, gray coded along run -> fault -> disabled -> resume
	typedef enum logic [1:0] {
		ST_RUN      = 2'b00,
		ST_FAULT    = 2'b01,
		ST_DISABLED = 2'b11,
		ST_RESUME   = 2'b10
	} sup_state_t;

	// byte phases inside one link frame
	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_REG  = 2'b01,
		PH_DATA = 2'b11
	} link_phase_t;

endpackage : ldd_ctrl_pkg

// ==== core/ldd_twi_link.sv ====
// two-wire register slave running on the link clock
`timescale 1ns/10ps
module ldd_twi_link
	import ldd_ctrl_pkg::*;
(
	input  wire logic       scl,
	input  wire logic       rst_n,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic [7:0] status_in,
	output logic [7:0]      ctrl_r,
	output logic [7:0]      eq_r,
	output logic [7:0]      cross_r,
	output logic [7:0]      lim_r,
	output logic [7:0]      range_r,
	output logic [7:0]      pdt_r,
	output logic            wr_tog_r
);

	logic        start_tog_r;
	logic        start_seen_r;
	logic [3:0]  bit_cnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  ptr_r;
	logic        sel_r;
	logic        rw_r;
	link_phase_t phase_r;
	logic [7:0]  stat_s1_r;
	logic [7:0]  stat_s2_r;
	logic [7:0]  rd_byte;
	logic [7:0]  byte_in;
	logic        new_frame;

	// ------------------------------------------------------------
	// start detection
	// ------------------------------------------------------------
	// start is sda falling while scl high; only this flop uses sda as a clock
	always_ff @(negedge sda_in or negedge rst_n) begin
		if (!rst_n) begin
			start_tog_r <= 1'b0;
		end else if (scl) begin
			start_tog_r <= ~start_tog_r;
		end
	end

	assign new_frame = (start_tog_r != start_seen_r);
	assign byte_in   = {shift_r[6:0], sda_in};

	// status byte from the system domain, two flops on the link clock
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			stat_s1_r <= 8'h00;
			stat_s2_r <= 8'h00;
		end else begin
			stat_s1_r <= status_in;
			stat_s2_r <= stat_s1_r;
		end
	end

	// read-back mux; unmapped offsets read as zero
	always_comb begin
		unique case (ptr_r)
			REG_CTRL:        rd_byte = ctrl_r;
			REG_EQ_SETTING:  rd_byte = eq_r;
			REG_CROSS_SHIFT: rd_byte = cross_r;
			REG_LIM_TRIM:    rd_byte = lim_r;
			REG_DRIVE_RANGE: rd_byte = range_r;
			REG_PD_TARGET:   rd_byte = pdt_r;
			REG_STATUS:      rd_byte = stat_s2_r;
			default:         rd_byte = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// bit and byte framing
	// ------------------------------------------------------------
	// nine edges per byte: eight data bits then the acknowledge slot
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			start_seen_r <= 1'b0;
			bit_cnt_r    <= 4'h0;
			shift_r      <= 8'h00;
			phase_r      <= PH_ADDR;
			sel_r        <= 1'b0;
			rw_r         <= 1'b0;
			ptr_r        <= 8'h00;
		end else begin
			start_seen_r <= start_tog_r;
			if (new_frame) begin
				bit_cnt_r <= 4'h1;
				shift_r   <= {7'h00, sda_in};
				phase_r   <= PH_ADDR;
				sel_r     <= 1'b0;
			end else if (bit_cnt_r < 4'h8) begin
				shift_r   <= byte_in;
				bit_cnt_r <= bit_cnt_r + 4'h1;
				if (bit_cnt_r == 4'h7 && phase_r == PH_ADDR) begin
					sel_r <= (byte_in[7:1] == DEV_ADDR);
					rw_r  <= byte_in[0];
				end
				if (bit_cnt_r == 4'h7 && phase_r == PH_REG && sel_r) begin
					ptr_r <= byte_in;
				end
			end else begin
				bit_cnt_r <= 4'h0;
				unique case (phase_r)
					PH_ADDR: phase_r <= rw_r ? PH_DATA : PH_REG;
					PH_REG:  phase_r <= PH_DATA;
					PH_DATA: phase_r <= PH_DATA;
					default: phase_r <= PH_ADDR;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// each write flips the toggle so the system side knows to take a copy
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r   <= CTRL_RST;
			eq_r     <= EQ_SETTING_RST;
			cross_r  <= CROSS_SHIFT_RST;
			lim_r    <= LIM_TRIM_RST;
			range_r  <= DRIVE_RANGE_RST;
			pdt_r    <= PD_TARGET_RST;
			wr_tog_r <= 1'b0;
		end else if (!new_frame && bit_cnt_r == 4'h7 && phase_r == PH_DATA
				&& sel_r && !rw_r) begin
			unique case (ptr_r)
				REG_CTRL:        ctrl_r  <= byte_in;
				REG_EQ_SETTING:  eq_r    <= byte_in;
				REG_CROSS_SHIFT: cross_r <= byte_in;
				REG_LIM_TRIM:    lim_r   <= {4'h0, byte_in[3:0]};
				REG_DRIVE_RANGE: range_r <= {7'h00, byte_in[0]};
				REG_PD_TARGET:   pdt_r   <= byte_in;
				default:         ;
			endcase
			wr_tog_r <= ~wr_tog_r;
		end
	end

	// ------------------------------------------------------------
	// open-drain drive on the falling edge
	// ------------------------------------------------------------
	// only a low is ever driven; the pull-up makes the ones
	always_ff @(negedge scl or negedge rst_n) begin
		if (!rst_n) begin
			sda_out  <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			sda_out <= 1'b0;
			if (bit_cnt_r == 4'h8 && sel_r && !(phase_r == PH_DATA && rw_r)) begin
				sda_oe_n <= 1'b0;
			end else if (sel_r && rw_r && phase_r == PH_DATA && bit_cnt_r < 4'h8) begin
				sda_oe_n <= rd_byte[3'h7 - bit_cnt_r[2:0]];
			end else begin
				sda_oe_n <= 1'b1;
			end
		end
	end

endmodule : ldd_twi_link

// ==== sim/ldd_fault_ctrl_properties.sv ====
// port-level assertions for the laser driver supervisor and tuning outputs
`timescale 1ns/10ps
module ldd_fault_ctrl_properties
	import ldd_ctrl_pkg::*;
(
	input wire logic       CLK_SYS,
	input wire logic       RSTN,
	input wire logic       SCL,
	input wire logic       SDA_OUT,
	input wire logic       SHUTDOWN_PIN,
	input wire logic       FAULT_OUTPUT,
	input wire logic       DRIVE_ON,
	input wire logic       EQ_ACTIVE,
	input wire logic [7:0] EQ_STRENGTH,
	input wire logic       XSHIFT_POSITIVE,
	input wire logic [6:0] XSHIFT_MAG,
	input wire logic       LIM_LOWER,
	input wire logic [2:0] LIM_MAG,
	input wire logic       MOD_HIGH_RANGE
);
	logic [3:0] idle_cnt_r; // cycles since the link clock was seen low
	logic [7:0] lo_cnt_r;   // cycles since the shutdown pin was seen high
	logic       busy;

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	// a register write can only land while the link is moving
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) idle_cnt_r <= 4'hF;
		else if (!SCL) idle_cnt_r <= 4'h0;
		else if (idle_cnt_r != 4'hF) idle_cnt_r <= idle_cnt_r + 4'h1;
	end
	// counts from the raw pin, so it always runs ahead of the synced copy
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) lo_cnt_r <= 8'hFF;
		else if (SHUTDOWN_PIN) lo_cnt_r <= 8'h00;
		else if (lo_cnt_r != 8'hFF) lo_cnt_r <= lo_cnt_r + 8'h01;
	end
	assign busy = (idle_cnt_r < 4'hC);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence pin_held;
		SHUTDOWN_PIN [*3];
	endsequence

	a_fault_drive_off: assert property (FAULT_OUTPUT |-> !DRIVE_ON)
		else $error("fault output high while drive is on");
	a_shutdown_clears: assert property (pin_held |=> !FAULT_OUTPUT && !DRIVE_ON)
		else $error("shutdown held but fault or drive still on");
	a_fault_latched: assert property ($fell(FAULT_OUTPUT) |->
		$past(SHUTDOWN_PIN, 2) || $past(SHUTDOWN_PIN, 3) || busy)
		else $error("fault output dropped with no disable");
	a_drive_cut: assert property ($fell(DRIVE_ON) |-> FAULT_OUTPUT || busy ||
		$past(SHUTDOWN_PIN, 2) || $past(SHUTDOWN_PIN, 3))
		else $error("drive dropped with no fault or disable");
	a_negate_wait: assert property ($rose(DRIVE_ON) |-> lo_cnt_r >= OFF_NEGATE_CYC)
		else $error("drive resumed before the negate time");
	a_tune_quiet: assert property (!busy |-> $stable({EQ_ACTIVE, EQ_STRENGTH,
		XSHIFT_POSITIVE, XSHIFT_MAG, LIM_LOWER, LIM_MAG, MOD_HIGH_RANGE}))
		else $error("tuning output moved without a link write");
	a_sda_open: assert property (SDA_OUT == 1'b0)
		else $error("data pin driven high");
endmodule : ldd_fault_ctrl_properties

bind ldd_fault_ctrl ldd_fault_ctrl_properties u_props (.CLK_SYS, .RSTN, .SCL, .SDA_OUT,
	.SHUTDOWN_PIN, .FAULT_OUTPUT, .DRIVE_ON, .EQ_ACTIVE, .EQ_STRENGTH, .XSHIFT_POSITIVE,
	.XSHIFT_MAG, .LIM_LOWER, .LIM_MAG, .MOD_HIGH_RANGE);

// ==== sim/twi_host_model.sv ====
// two-wire controller model: makes the link clock and writes registers
`timescale 1ns/10ps
module twi_host_model
	import ldd_ctrl_pkg::*;
(
	output logic     SCL,
	output logic     SDA_IN,
	input wire logic SDA_OE_N
);
	logic rel_r = 1'b1; // host side of the wire released

	// open drain with pull-up: the wire is low while either side pulls
	assign SDA_IN = rel_r & SDA_OE_N;
	// link clock stands high between frames
	initial SCL = 1'b1;

	// one byte msb first, then the ack bit sampled on the rising edge
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			rel_r = b[i];
			#3 SCL = 1'b1;
			#3 SCL = 1'b0;
		end
		rel_r = 1'b1;
		#3 SCL = 1'b1;
		ack = !SDA_IN;
		#3 SCL = 1'b0;
	endtask : put_byte

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, d,
		output logic [2:0] acks);
		rel_r = 1'b0; // start: data falls while clock is high
		#3 SCL = 1'b0;
		put_byte({dev, 1'b0}, acks[2]);
		put_byte(a, acks[1]);
		put_byte(d, acks[0]);
		rel_r = 1'b0;
		#3 SCL = 1'b1;
		#3 rel_r = 1'b1; // stop
		#3;
	endtask : write_reg
endmodule : twi_host_model

// ==== sim/testbench.sv ====
// self-checking bench for the laser driver control logic
`timescale 1ns/10ps
module testbench
	import ldd_ctrl_pkg::*;
;
	logic       CLK_SYS, RSTN, SCL, SDA_IN, SDA_OUT, SDA_OE_N, SHUTDOWN_PIN;
	logic       BIAS_MON_ABOVE_REF, FAULT_OUTPUT, DRIVE_ON, EQ_ACTIVE;
	logic       XSHIFT_POSITIVE, LIM_LOWER, MOD_HIGH_RANGE;
	logic [7:0] PD_CURRENT, EQ_STRENGTH, v;
	logic [9:0] BIAS_DAC;
	logic [6:0] XSHIFT_MAG;
	logic [2:0] LIM_MAG, acks;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cyc = 0;

	ldd_fault_ctrl dut (.CLK_SYS, .RSTN, .SCL, .SDA_IN, .SDA_OUT, .SDA_OE_N,
		.SHUTDOWN_PIN, .BIAS_MON_ABOVE_REF, .PD_CURRENT, .BIAS_DAC, .FAULT_OUTPUT,
		.DRIVE_ON, .EQ_ACTIVE, .EQ_STRENGTH, .XSHIFT_POSITIVE, .XSHIFT_MAG,
		.LIM_LOWER, .LIM_MAG, .MOD_HIGH_RANGE);
	twi_host_model host (.SCL, .SDA_IN, .SDA_OE_N);

	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end

	// ----------------------------------------
	// helpers and expectations
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict

	function automatic logic [7:0] ctrl_val(input logic eq, det, on);
		ctrl_val = 8'h00;
		ctrl_val[CTRL_EQ_ON_BIT] = eq;
		ctrl_val[CTRL_FAULT_DET] = det;
		ctrl_val[CTRL_OUTPUT_ON] = on;
	endfunction : ctrl_val

	// strongest equalization at the lowest setting code
	function automatic logic [7:0] eq_exp(input logic [7:0] s);
		eq_exp = 8'hFF - s;
	endfunction : eq_exp

	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask : tick

	// link frames start 7 ns after a system edge so the two clocks keep a fixed phase
	task automatic wr(input logic [6:0] dev, input logic [7:0] a, d);
		@(posedge CLK_SYS);
		#7;
		host.write_reg(dev, a, d, acks);
		tick(8);
	endtask : wr

	// holding the pin for the latch reset time is what clears a fault
	task automatic shut(input int hold);
		SHUTDOWN_PIN <= 1'b1;
		tick(hold);
		check(8'(FAULT_OUTPUT), 8'h00);
		SHUTDOWN_PIN <= 1'b0;
		tick(5);
	endtask : shut

	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		RSTN = 1'b0;
		SHUTDOWN_PIN = 1'b0;
		BIAS_MON_ABOVE_REF = 1'b0;
		PD_CURRENT = 8'h00;
		BIAS_DAC = 10'h000;
		void'($urandom(32'hEFE6));
		tick(6);
		RSTN <= 1'b1;
		tick(3);
		check(8'(DRIVE_ON), 8'h01);
		check(8'(EQ_ACTIVE), 8'h00);
		// tuning fields: both corner codes, then random ones
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			wr(DEV_ADDR, REG_EQ_SETTING, v);
			wr(DEV_ADDR, REG_CROSS_SHIFT, v);
			wr(DEV_ADDR, REG_LIM_TRIM, v);
			wr(DEV_ADDR, REG_DRIVE_RANGE, v);
			wr(DEV_ADDR, REG_CTRL, ctrl_val(v[1] | (i == 0), 1'b0, 1'b1));
			check(8'(acks), 8'h07);
			check(8'(EQ_ACTIVE), 8'(v[1] | (i == 0)));
			if (EQ_ACTIVE === 1'b1) check(EQ_STRENGTH, eq_exp(v));
			check(8'(XSHIFT_POSITIVE), 8'(v[CROSS_SIGN_BIT]));
			check(8'(XSHIFT_MAG), 8'(v[6:0]));
			check(8'(LIM_LOWER), 8'(v[LIM_DIR_BIT]));
			check(8'(LIM_MAG), 8'(v[2:0]));
			check(8'(MOD_HIGH_RANGE), 8'(v[RANGE_HIGH_BIT]));
		end
		// another address is refused and changes nothing
		wr(DEV_ADDR ^ 7'h01, REG_DRIVE_RANGE, ~v);
		check(8'(acks), 8'h00);
		check(8'(MOD_HIGH_RANGE), 8'(v[RANGE_HIGH_BIT]));
		// monitor fault ignored with detection off, latched with it on
		BIAS_MON_ABOVE_REF <= 1'b1;
		tick(6);
		check(8'({FAULT_OUTPUT, DRIVE_ON}), 8'h01);
		wr(DEV_ADDR, REG_CTRL, ctrl_val(1'b0, 1'b1, 1'b1));
		check(8'({FAULT_OUTPUT, DRIVE_ON}), 8'h02);
		BIAS_MON_ABOVE_REF <= 1'b0;
		tick(6);
		check(8'(FAULT_OUTPUT), 8'h01);
		shut(FAULT_RESET_CYC + 5);
		check(8'(DRIVE_ON), 8'h00);
		tick(OFF_NEGATE_CYC + 5);
		check(8'(DRIVE_ON), 8'h01);
		// photodiode threshold at one and a half times the target
		PD_CURRENT <= 8'd192;
		tick(6);
		check(8'(FAULT_OUTPUT), 8'h00);
		PD_CURRENT <= 8'd193;
		tick(6);
		check(8'(FAULT_OUTPUT), 8'h01);
		PD_CURRENT <= 8'd0;
		// clear through the output on bit this time
		wr(DEV_ADDR, REG_CTRL, ctrl_val(1'b0, 1'b1, 1'b0));
		check(8'(FAULT_OUTPUT), 8'h00);
		tick(FAULT_RESET_CYC);
		wr(DEV_ADDR, REG_CTRL, ctrl_val(1'b0, 1'b1, 1'b1));
		tick(OFF_NEGATE_CYC + 5);
		check(8'(DRIVE_ON), 8'h01);
		check(8'(XSHIFT_MAG), 8'(v[6:0]));
		// converter step: exactly half is fine, below half is a fault
		BIAS_DAC <= 10'd400;
		tick(6);
		BIAS_DAC <= 10'd200;
		tick(6);
		check(8'(FAULT_OUTPUT), 8'h00);
		BIAS_DAC <= 10'd400;
		tick(6);
		BIAS_DAC <= 10'd199;
		tick(6);
		check(8'(FAULT_OUTPUT), 8'h01);
		// fault still present when the pin drops: straight back to fault
		BIAS_MON_ABOVE_REF <= 1'b1;
		shut(FAULT_RESET_CYC + 5);
		check(8'({FAULT_OUTPUT, DRIVE_ON}), 8'h02);
		BIAS_MON_ABOVE_REF <= 1'b0;
		// a disable shorter than the latch reset time leaves the fault latched
		shut(4);
		check(8'({FAULT_OUTPUT, DRIVE_ON}), 8'h02);
		shut(FAULT_RESET_CYC + 5);
		tick(OFF_NEGATE_CYC + 5);
		check(8'({FAULT_OUTPUT, DRIVE_ON}), 8'h01);
		print_verdict();
	end
endmodule : testbench
